// ===== rtl/ssam_pkg.sv
package ssam_pkg;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_HZ        = 40_000_000;
	localparam int TICK_US       = 1000;
	localparam int TICK_CYC      = CLK_HZ / 1_000_000 * TICK_US;
	localparam int SERVO_OFF_MS  = 1000;
	localparam int FLASH_HALF_MS = 250;

	// ****************************************
	// Codes and sizes
	// ****************************************
	localparam int         N_ALM        = 32;
	localparam int         N_WARN       = 4;
	localparam logic [7:0] ALM_BASE     = 8'h60;
	localparam logic [7:0] WARN_BASE    = 8'he8;
	localparam logic [4:0] CH_B         = 5'h0b;
	localparam logic [4:0] CH_C         = 5'h0c;
	localparam logic [4:0] CH_D         = 5'h0d;
	localparam logic [4:0] CH_WARN_BASE = 5'h18;
	localparam logic [4:0] IDX_60       = 5'h00;
	localparam logic [4:0] IDX_6A       = 5'h0a;
	localparam logic [4:0] IDX_6E       = 5'h0e;
	localparam logic [4:0] IDX_71       = 5'h11;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0] OFS_ALM_STAT = 8'h00;
	localparam logic [7:0] OFS_STATE    = 8'h04;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
	localparam logic [7:0] OFS_IRQ_EN   = 8'h0c;
	localparam logic [7:0] OFS_IRQ_CLR  = 8'h10;
	localparam logic [7:0] OFS_CTRL     = 8'h14;
	localparam int         CTRL_KEY_BIT   = 0;
	localparam int         CTRL_NCPON_BIT = 1;
	localparam int         IRQ_W          = 2;
	localparam int         IRQ_ALM_BIT    = 0;
	localparam int         IRQ_WARN_BIT   = 1;
	localparam int         ST_WARN_LSB    = 0;
	localparam int         ST_DISP_LSB    = 4;
	localparam int         ST_READY_BIT   = 6;
	localparam int         ST_ESTOP_BIT   = 7;
	localparam logic [1:0] IRQ_EN_RST     = 2'h0;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [1:0] {
		ST_RDY_OFF = 2'b00,
		ST_SRV_OFF = 2'b01,
		ST_SRV_ON  = 2'b10
	} ssam_disp_st_t;

	typedef enum logic [2:0] {
		DW_NONE   = 3'b000,
		DW_CONT   = 3'b001,
		DW_TRANS  = 3'b010,
		DW_RDYOFF = 3'b011,
		DW_PWRON  = 3'b100,
		DW_NCPON  = 3'b101,
		DW_RDYON  = 3'b110
	} ssam_win_t;

	typedef enum logic [1:0] {
		REL_NONE = 2'b00,
		REL_UNIT = 2'b01,
		REL_CTRL = 2'b10,
		REL_KEY  = 2'b11
	} ssam_rel_t;

	// Detection window per alarm index (code minus 60h)
	function automatic ssam_win_t ssam_alarm_win(input logic [4:0] idx);
		case (idx)
			5'h00, 5'h01, 5'h02, 5'h03: ssam_alarm_win = DW_CONT;
			5'h05, 5'h07, 5'h09, 5'h0c: ssam_alarm_win = DW_TRANS;
			5'h08, 5'h0f:               ssam_alarm_win = DW_CONT;
			5'h0a, 5'h0b:               ssam_alarm_win = DW_RDYOFF;
			5'h0d, 5'h16:               ssam_alarm_win = DW_NCPON;
			5'h0e:                      ssam_alarm_win = DW_PWRON;
			5'h11:                      ssam_alarm_win = DW_RDYON;
			5'h13, 5'h14, 5'h15, 5'h17: ssam_alarm_win = DW_CONT;
			default:                    ssam_alarm_win = DW_NONE;
		endcase
	endfunction : ssam_alarm_win

	// Release class per alarm index
	function automatic ssam_rel_t ssam_alarm_rel(input logic [4:0] idx);
		case (idx)
			5'h08, 5'h0e, 5'h0f, 5'h16: ssam_alarm_rel = REL_UNIT;
			5'h11, 5'h15:               ssam_alarm_rel = REL_KEY;
			5'h04, 5'h06, 5'h10, 5'h12: ssam_alarm_rel = REL_NONE;
			5'h18, 5'h19, 5'h1a, 5'h1b: ssam_alarm_rel = REL_NONE;
			5'h1c, 5'h1d, 5'h1e, 5'h1f: ssam_alarm_rel = REL_NONE;
			default:                    ssam_alarm_rel = REL_CTRL;
		endcase
	endfunction : ssam_alarm_rel

endpackage : ssam_pkg

// ===== rtl/ssam_tick.sv
module ssam_tick #(
	parameter int DIV = ssam_pkg::TICK_CYC
) (
	// Clock and reset
	input  wire logic core_clk_i,
	input  wire logic rst_b_i,
	// Enable pulse
	output logic      tick_o
);
	import ssam_pkg::*;

	localparam int CW = $clog2(DIV);
	localparam logic [CW-1:0] LAST = CW'(DIV - 1);

	logic [CW-1:0] cnt_r;

	if (DIV < 2) begin : g_chk
		$error("ssam_tick: DIV must be at least 2");
	end

	wire wrap = (cnt_r == LAST);

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt_r  <= '0;
			tick_o <= 1'b0;
		end else begin
			cnt_r  <= wrap ? '0 : cnt_r + 1'b1;
			tick_o <= wrap;
		end
	end

endmodule : ssam_tick

// ===== rtl/ssam_top.sv
//Operation
// - Indicator shows ready-off code b from power-on until emergency stop release.
// - After release show servo-off code c for one second, then servo-on.
// - Servo-on code d shown while released and operation permitted.
// - Active alarm or warning code flashes; steady code means no alarm.
// - Display character differs from number: 60-6F to 0-F, 70-77 G-n, E8-EB o-r.
// - Alarms 60-7F are supply faults reported to the drive over the cable.
// - Each alarm has release: unit repower, controller repower, or reset key.
// - Checks 60,61,62,63,68,73,74,75,77 run continuously from power-on.
// - 65,67,69,6C checked at ready-on transition; 6A,6B only while ready off.
// - 6E checked right after power-on, unit repower release; 6F always.
// - 6D, 76 and EA evaluated when the controller powers on.
// - 71, E9, EB evaluated only while ready on; 71 cleared by reset key.
// - Warnings E8-EB are not latched and need no reset to clear.
//
// Added by the designer: the register addresses and the APB slave port.
module ssam_top #(
	parameter int TICK_DIV = ssam_pkg::TICK_CYC
) (
	// Clock and reset
	input  wire logic                        core_clk_i,
	input  wire logic                        rst_b_i,
	// APB slave
	input  wire logic                        psel_i,
	input  wire logic                        penable_i,
	input  wire logic                        pwrite_i,
	input  wire logic [7:0]                  paddr_i,
	input  wire logic [31:0]                 pwdata_i,
	output logic      [31:0]                 prdata_o,
	output logic                             pready_o,
	output logic                             pslverr_o,
	// Fault sensing and emergency stop
	input  wire logic [ssam_pkg::N_ALM-1:0]  fault_i,
	input  wire logic [ssam_pkg::N_WARN-1:0] warn_i,
	input  wire logic                        estop_rel_i,
	// Seven-segment indicator
	output logic      [6:0]                  seg_o,
	output logic      [4:0]                  disp_char_o,
	output logic                             disp_flash_o,
	// Supply comm cable to drive unit
	output logic      [7:0]                  cable_alarm_no_o,
	output logic                             cable_alarm_act_o,
	// Interrupt
	output logic                             irq_o
);
	import ssam_pkg::*;

	localparam logic [9:0] SRV_LIM = 10'(SERVO_OFF_MS - 1);
	localparam logic [7:0] FL_LIM  = 8'(FLASH_HALF_MS - 1);
	localparam int         SW      = N_ALM + N_WARN + 1;

	if (TICK_DIV < 2) begin : g_chk
		$error("ssam_top: TICK_DIV must be at least 2");
	end

	// ****************************************
	// Functions
	// ****************************************
	function automatic logic [4:0] lowest_set(input logic [31:0] v);
		lowest_set = 5'h00;
		for (int i = 31; i >= 0; i--) begin
			if (v[i]) begin
				lowest_set = 5'(i);
			end
		end
	endfunction : lowest_set

	function automatic logic win_ok(input ssam_win_t w, input logic rdy, input logic trans,
	                                input logic pwron, input logic ncpon);
		case (w)
			DW_CONT:   win_ok = 1'b1;
			DW_TRANS:  win_ok = trans;
			DW_RDYOFF: win_ok = !rdy;
			DW_PWRON:  win_ok = pwron;
			DW_NCPON:  win_ok = ncpon;
			DW_RDYON:  win_ok = rdy;
			default:   win_ok = 1'b0;
		endcase
	endfunction : win_ok

	function automatic logic [6:0] seg_of(input logic [4:0] ch);
		case (ch)
			5'h00: seg_of = 7'h3f;
			5'h01: seg_of = 7'h06;
			5'h02: seg_of = 7'h5b;
			5'h03: seg_of = 7'h4f;
			5'h04: seg_of = 7'h66;
			5'h05: seg_of = 7'h6d;
			5'h06: seg_of = 7'h7d;
			5'h07: seg_of = 7'h07;
			5'h08: seg_of = 7'h7f;
			5'h09: seg_of = 7'h6f;
			5'h0a: seg_of = 7'h77;
			5'h0b: seg_of = 7'h7c;
			5'h0c: seg_of = 7'h58;
			5'h0d: seg_of = 7'h5e;
			5'h0e: seg_of = 7'h79;
			5'h0f: seg_of = 7'h71;
			5'h10: seg_of = 7'h3d;
			5'h11: seg_of = 7'h76;
			5'h12: seg_of = 7'h04;
			5'h13: seg_of = 7'h1e;
			5'h14: seg_of = 7'h75;
			5'h15: seg_of = 7'h38;
			5'h16: seg_of = 7'h37;
			5'h17: seg_of = 7'h54;
			5'h18: seg_of = 7'h5c;
			5'h19: seg_of = 7'h73;
			5'h1a: seg_of = 7'h67;
			5'h1b: seg_of = 7'h50;
			default: seg_of = 7'h40;
		endcase
	endfunction : seg_of

	// ****************************************
	// Input synchronisers and power-on pulse
	// ****************************************
	logic [SW-1:0] sync1_r;
	logic [SW-1:0] sync2_r;
	logic [1:0]    por_cnt_r;

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sync1_r   <= '0;
			sync2_r   <= '0;
			por_cnt_r <= 2'h0;
		end else begin
			sync1_r   <= {estop_rel_i, warn_i, fault_i};
			sync2_r   <= sync1_r;
			por_cnt_r <= (por_cnt_r == 2'h3) ? por_cnt_r : por_cnt_r + 2'h1;
		end
	end

	wire [N_ALM-1:0]  fault_s = sync2_r[N_ALM-1:0];
	wire [N_WARN-1:0] warn_s  = sync2_r[N_ALM+N_WARN-1:N_ALM];
	wire              estop_s = sync2_r[SW-1];
	// Synchronisers are full only from the second edge on
	wire              pwron_p = (por_cnt_r == 2'h2);

	// ****************************************
	// APB slave
	// ****************************************
	logic [IRQ_W-1:0] irq_en_r;
	logic [IRQ_W-1:0] irq_stat_r;
	logic [N_ALM-1:0] alm_r;
	logic [3:0]       warn_live;
	ssam_disp_st_t    st_r;

	wire apb_acc   = psel_i & penable_i;
	wire apb_first = apb_acc & !pready_o;
	wire wr_en     = apb_acc & pready_o & pwrite_i;
	wire hit_alm   = (paddr_i == OFS_ALM_STAT);
	wire hit_state = (paddr_i == OFS_STATE);
	wire hit_ist   = (paddr_i == OFS_IRQ_STAT);
	wire hit_ien   = (paddr_i == OFS_IRQ_EN);
	wire hit_iclr  = (paddr_i == OFS_IRQ_CLR);
	wire hit_ctrl  = (paddr_i == OFS_CTRL);
	wire mapped    = hit_alm | hit_state | hit_ist | hit_ien | hit_iclr | hit_ctrl;
	// Controller events arrive as self-clearing command bits
	wire key_p     = wr_en & hit_ctrl & pwdata_i[CTRL_KEY_BIT];
	wire ncpon_p   = wr_en & hit_ctrl & pwdata_i[CTRL_NCPON_BIT];
	wire [IRQ_W-1:0] iclr = (wr_en & hit_iclr) ? pwdata_i[IRQ_W-1:0] : '0;

	wire [31:0] state_word = {24'h0, estop_s, (st_r != ST_RDY_OFF), st_r, warn_live};
	wire [31:0] rd_mux = hit_alm   ? alm_r :
	                     hit_state ? state_word :
	                     hit_ist   ? {30'h0, irq_stat_r} :
	                     hit_ien   ? {30'h0, irq_en_r} : 32'h0;

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o  <= 32'h0;
			irq_en_r  <= IRQ_EN_RST;
		end else begin
			pready_o  <= apb_first;
			pslverr_o <= apb_first & !mapped;
			prdata_o  <= (apb_first & !pwrite_i) ? rd_mux : 32'h0;
			if (wr_en & hit_ien) begin
				irq_en_r <= pwdata_i[IRQ_W-1:0];
			end
		end
	end

	// ****************************************
	// Status sequence and timebase
	// ****************************************
	logic          tick;
	logic [9:0]    cnt_r;
	logic [7:0]    fl_cnt_r;
	logic          phase_r;
	ssam_disp_st_t st_nxt;

	ssam_tick #(.DIV(TICK_DIV)) u_tick (
		.core_clk_i (core_clk_i),
		.rst_b_i    (rst_b_i),
		.tick_o     (tick)
	);

	wire any_alm   = |alm_r;
	wire srv_done  = tick & (cnt_r == SRV_LIM);

	always_comb begin
		st_nxt = st_r;
		case (st_r)
			ST_RDY_OFF: if (estop_s && !any_alm) st_nxt = ST_SRV_OFF;
			ST_SRV_OFF: begin
				if (!estop_s || any_alm) st_nxt = ST_RDY_OFF;
				else if (srv_done) st_nxt = ST_SRV_ON;
			end
			ST_SRV_ON:  if (!estop_s || any_alm) st_nxt = ST_RDY_OFF;
			default:    st_nxt = ST_RDY_OFF;
		endcase
	end

	wire ready   = (st_r != ST_RDY_OFF);
	wire trans_p = (st_r == ST_RDY_OFF) && (st_nxt == ST_SRV_OFF);
	wire fl_wrap = tick & (fl_cnt_r == FL_LIM);

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_r     <= ST_RDY_OFF;
			cnt_r    <= 10'h000;
			fl_cnt_r <= 8'h00;
			phase_r  <= 1'b1;
		end else begin
			st_r     <= st_nxt;
			cnt_r    <= (st_r != ST_SRV_OFF) ? 10'h000 : (tick ? cnt_r + 10'h001 : cnt_r);
			fl_cnt_r <= fl_wrap ? 8'h00 : (tick ? fl_cnt_r + 8'h01 : fl_cnt_r);
			phase_r  <= fl_wrap ? !phase_r : phase_r;
		end
	end

	// ****************************************
	// Alarm latches and warnings
	// ****************************************
	logic [N_ALM-1:0] det;
	logic [N_ALM-1:0] clr;
	logic             ea_r;
	logic [3:0]       warn_prev_r;

	always_comb begin
		for (int i = 0; i < N_ALM; i++) begin
			// Windows per code
			det[i] = fault_s[i] & win_ok(ssam_alarm_win(5'(i)), ready, trans_p, pwron_p, ncpon_p);
			case (ssam_alarm_rel(5'(i)))
				REL_CTRL: clr[i] = ncpon_p;
				REL_KEY:  clr[i] = key_p;
				default:  clr[i] = 1'b0;
			endcase
		end
	end

	// New detections win over a release in the same cycle
	wire [N_ALM-1:0] alm_nxt = (alm_r & ~clr) | det;
	// EA is caught at controller power-on and dropped once its input falls
	assign warn_live = {warn_s[3] & ready, ea_r & warn_s[2], warn_s[1] & ready, warn_s[0]};
	wire any_warn = |warn_live;
	wire [IRQ_W-1:0] ev = {|(warn_live & ~warn_prev_r), |(alm_nxt & ~alm_r)};

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			alm_r       <= '0;
			ea_r        <= 1'b0;
			warn_prev_r <= 4'h0;
			irq_stat_r  <= '0;
			irq_o       <= 1'b0;
		end else begin
			alm_r       <= alm_nxt;
			ea_r        <= (ncpon_p & warn_s[2]) | (ea_r & warn_s[2]);
			warn_prev_r <= warn_live;
			irq_stat_r  <= (irq_stat_r & ~iclr) | ev;
			irq_o       <= |(irq_stat_r & irq_en_r);
		end
	end

	// ****************************************
	// Indicator and cable report
	// ****************************************
	wire [4:0] alm_idx  = lowest_set(alm_r);
	wire [4:0] warn_idx = lowest_set({28'h0, warn_live});
	wire [4:0] st_char  = (st_r == ST_SRV_ON) ? CH_D : (st_r == ST_SRV_OFF) ? CH_C : CH_B;
	wire [4:0] char_nxt = any_alm ? alm_idx : any_warn ? CH_WARN_BASE + warn_idx : st_char;
	wire       flash    = any_alm | any_warn;
	wire [7:0] no_nxt   = any_alm ? (ALM_BASE | {3'h0, alm_idx}) :
	                      any_warn ? WARN_BASE + {6'h0, warn_idx[1:0]} : 8'h00;

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			seg_o             <= 7'h00;
			disp_char_o       <= CH_B;
			disp_flash_o      <= 1'b0;
			cable_alarm_no_o  <= 8'h00;
			cable_alarm_act_o <= 1'b0;
		end else begin
			seg_o             <= (flash && !phase_r) ? 7'h00 : seg_of(char_nxt);
			disp_char_o       <= char_nxt;
			disp_flash_o      <= flash;
			cable_alarm_no_o  <= no_nxt;
			cable_alarm_act_o <= flash;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!rst_b_i);

	sequence s_srv_off_entry;
		(st_r == ST_RDY_OFF) ##1 (st_r == ST_SRV_OFF);
	endsequence

	a_ready_off_code: assert property ((st_r == ST_RDY_OFF && !any_alm && !any_warn)
		|=> (disp_char_o == CH_B && !disp_flash_o)) else $error("ready-off code wrong");
	a_servo_off_time: assert property ((st_r == ST_SRV_OFF && st_nxt == ST_SRV_ON)
		|-> (tick && cnt_r == SRV_LIM)) else $error("servo-off left early");
	a_servo_off_start: assert property (s_srv_off_entry |-> (cnt_r == 10'h000))
		else $error("servo-off count not cleared");
	a_servo_on_code: assert property ((st_r == ST_SRV_ON && !any_alm && !any_warn)
		|=> (disp_char_o == CH_D && !disp_flash_o)) else $error("servo-on code wrong");
	a_alarm_flash: assert property (any_alm |=> (disp_flash_o && cable_alarm_act_o))
		else $error("alarm not flashing");
	a_char_map: assert property ((cable_alarm_act_o && cable_alarm_no_o[7:5] == 3'b011)
		|-> (disp_char_o == cable_alarm_no_o[4:0])) else $error("display char mismatch");
	a_cable_report: assert property (any_alm |=> (cable_alarm_act_o &&
		cable_alarm_no_o == (ALM_BASE | {3'h0, $past(alm_idx)}))) else $error("alarm not on cable");
	a_latch_hold: assert property ((!key_p && !ncpon_p)
		|=> ((alm_r & $past(alm_r)) == $past(alm_r))) else $error("latched alarm lost");
	a_cont_check: assert property (fault_s[IDX_60] |=> alm_r[IDX_60])
		else $error("continuous check missed");
	a_melt_window: assert property ((ready && !alm_r[IDX_6A]) |=> !alm_r[IDX_6A])
		else $error("melt check while ready on");
	a_memory_hold: assert property (alm_r[IDX_6E] |=> alm_r[IDX_6E])
		else $error("memory error released");
	a_rdyon_window: assert property ((!ready && !alm_r[IDX_71]) |=> !alm_r[IDX_71])
		else $error("ready-on check while ready off");
	a_warn_unlatched: assert property ((!warn_s[0] && !warn_s[1] && !warn_s[3] && !warn_s[2])
		|-> !any_warn) else $error("warning latched");

endmodule : ssam_top

// ===== verif/ssam_drive_model.sv
module ssam_drive_model (
	// Clock and reset
	input  wire logic       core_clk_i,
	input  wire logic       rst_b_i,
	// Supply comm cable
	input  wire logic [7:0] cable_alarm_no_i,
	input  wire logic       cable_alarm_act_i,
	// Drive indicator and controller report
	output logic      [7:0] drv_disp_o,
	output logic      [7:0] nc_alarm_o
);
	timeunit 1ns;
	timeprecision 100ps;

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			drv_disp_o <= 8'h00;
			nc_alarm_o <= 8'h00;
		end else begin
			// Same edge for both, so indicator and report never disagree
			drv_disp_o <= cable_alarm_act_i ? cable_alarm_no_i : 8'h00;
			// Only the supply range becomes an axis alarm
			nc_alarm_o <= (cable_alarm_act_i && cable_alarm_no_i[7:5] == 3'b011) ? cable_alarm_no_i : 8'h00;
		end
	end

endmodule : ssam_drive_model

// ===== verif/testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	import ssam_pkg::*;

	// ****************************************
	// Signals and model state
	// ****************************************
	localparam logic [31:0] CONT_M = 32'h00b8810f;
	localparam logic [31:0] ROFF_M = 32'h00000c00;
	localparam logic [31:0] UNIT_REL_M = 32'h0040c100;
	localparam logic [31:0] KEY_REL_M  = 32'h00220000;
	logic              clk = 1'b0;
	logic              rst_b = 1'b0;
	logic              psel = 1'b0;
	logic              pen = 1'b0;
	logic              pwr = 1'b0;
	logic [7:0]        pa = 8'h00;
	logic [31:0]       pwd = 32'h0;
	logic [31:0]       prd;
	logic              prdy;
	logic              perr;
	logic [N_ALM-1:0]  flt = '0;
	logic [N_WARN-1:0] wrn = '0;
	logic              estop = 1'b0;
	logic [6:0]        seg;
	logic [4:0]        ch;
	logic              flash;
	logic [7:0]        cno;
	logic              act;
	logic              irq;
	logic [7:0]        ddisp;
	logic [7:0]        ncal;
	logic [31:0]       rd;
	logic              er;
	logic [31:0]       alm_m = '0;
	logic [3:0]        wm = '0;
	logic [4:0]        st_m = CH_B;
	int                miscompares = 0;
	int                total_checks = 0;
	int                seed = 72;

	always #12.5 clk = ~clk;

	ssam_top #(.TICK_DIV(4)) dut (
		.core_clk_i(clk), .rst_b_i(rst_b), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
		.paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd), .pready_o(prdy), .pslverr_o(perr),
		.fault_i(flt), .warn_i(wrn), .estop_rel_i(estop), .seg_o(seg), .disp_char_o(ch),
		.disp_flash_o(flash), .cable_alarm_no_o(cno), .cable_alarm_act_o(act), .irq_o(irq)
	);

	ssam_drive_model drive (
		.core_clk_i(clk), .rst_b_i(rst_b), .cable_alarm_no_i(cno), .cable_alarm_act_i(act),
		.drv_disp_o(ddisp), .nc_alarm_o(ncal)
	);

	// ****************************************
	// Tasks
	// ****************************************
	task automatic results;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : results

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
			miscompares++;
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		pa <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		// Only the watchdog ends a wait that never completes
		do begin
			@(posedge clk);
		end while (prdy !== 1'b1);
		rd = prd;
		er = perr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask : apb

	// Model of what indicator, cable and status must show
	task automatic check_all;
		logic [4:0] ec;
		logic [7:0] en;
		logic       f;
		logic       a;
		ec = st_m;
		en = 8'h00;
		f = 1'b0;
		a = 1'b0;
		for (int j = 3; j >= 0; j--)
			if (wm[j]) begin
				ec = CH_WARN_BASE + 5'(j);
				en = WARN_BASE + 8'(j);
				f = 1'b1;
			end
		// Alarms hide warnings and status; lowest code wins
		for (int i = 23; i >= 0; i--)
			if (alm_m[i]) begin
				ec = 5'(i);
				en = ALM_BASE + 8'(i);
				f = 1'b1;
				a = 1'b1;
			end
		chk(32'(ch), 32'(ec));
		chk(32'(cno), 32'(en));
		chk(32'(ddisp), 32'(en));
		chk(32'(flash), 32'(f));
		chk(32'(act), 32'(f));
		chk(32'(ncal), a ? 32'(en) : 32'h0);
		apb(1'b0, OFS_ALM_STAT, 32'h0);
		chk(rd, alm_m);
	endtask : check_all

	task automatic ctrl(input int b);
		apb(1'b1, OFS_CTRL, 32'h1 << b);
		if (b == CTRL_KEY_BIT)
			alm_m = alm_m & ~KEY_REL_M;
		else
			alm_m = alm_m & (UNIT_REL_M | KEY_REL_M);
		cyc(6);
	endtask : ctrl

	task automatic pulse(input int i, input logic l);
		@(posedge clk);
		flt[i] <= 1'b1;
		cyc(4 + {$random(seed)} % 8);
		flt[i] <= 1'b0;
		cyc(6);
		if (l)
			alm_m[i] = 1'b1;
		check_all();
	endtask : pulse

	// ****************************************
	// Scenarios
	// ****************************************
	initial begin
		#500000;
		miscompares++;
		results();
	end

	initial begin
		int i;
		int off;
		logic e;
		cyc(6);
		rst_b <= 1'b1;
		cyc(4);
		check_all();
		chk(32'(seg), 32'h7c);
		apb(1'b0, OFS_IRQ_EN, 32'h0);
		chk(rd, 32'(IRQ_EN_RST));
		apb(1'b0, 8'h18, 32'h0);
		chk({rd[30:0], er}, 32'h1);
		apb(1'b1, OFS_ALM_STAT, 32'hffffffff);
		off = {$random(seed)} % 24;
		for (int k = 0; k < 24; k++) begin
			i = (k + off) % 24;
			e = k[0];
			apb(1'b1, OFS_IRQ_EN, 32'(e));
			pulse(i, CONT_M[i] | ROFF_M[i]);
			chk(32'(irq), 32'(e & (CONT_M[i] | ROFF_M[i])));
			apb(1'b1, OFS_IRQ_CLR, 32'h3);
			cyc(3);
			chk(32'(irq), 32'h0);
			ctrl(CTRL_KEY_BIT);
			check_all();
			ctrl(CTRL_NCPON_BIT);
			check_all();
		end
		@(posedge clk);
		rst_b <= 1'b0;
		flt[14] <= 1'b1;
		cyc(3);
		rst_b <= 1'b1;
		cyc(8);
		flt[14] <= 1'b0;
		alm_m = 32'h4000;
		cyc(4);
		check_all();
		ctrl(CTRL_NCPON_BIT);
		check_all();
		// Memory error blocks ready-on, so re-power the unit first
		@(posedge clk);
		rst_b <= 1'b0;
		cyc(3);
		rst_b <= 1'b1;
		alm_m = '0;
		cyc(4);
		check_all();
		estop <= 1'b1;
		cyc(8);
		st_m = CH_C;
		check_all();
		apb(1'b0, OFS_STATE, 32'h0);
		chk(32'(rd[5:4]), 32'h1);
		cyc(3930);
		check_all();
		cyc(100);
		st_m = CH_D;
		check_all();
		wm = (4'($random(seed)) & 4'ha) | 4'h1;
		wrn <= wm;
		cyc(8);
		check_all();
		apb(1'b0, OFS_IRQ_STAT, 32'h0);
		chk(32'(rd[IRQ_WARN_BIT]), 32'h1);
		wrn <= 4'h0;
		wm = 4'h0;
		cyc(8);
		check_all();
		pulse(10, 1'b0);
		st_m = CH_B;
		pulse(17, 1'b1);
		estop <= 1'b0;
		ctrl(CTRL_KEY_BIT);
		check_all();
		pulse(17, 1'b0);
		flt[5] <= 1'b1;
		estop <= 1'b1;
		cyc(10);
		alm_m[5] = 1'b1;
		flt[5] <= 1'b0;
		estop <= 1'b0;
		cyc(6);
		check_all();
		ctrl(CTRL_NCPON_BIT);
		check_all();
		flt[13] <= 1'b1;
		flt[22] <= 1'b1;
		wrn[2] <= 1'b1;
		cyc(4);
		check_all();
		ctrl(CTRL_NCPON_BIT);
		alm_m = alm_m | 32'h00402000;
		wm = 4'h4;
		flt[13] <= 1'b0;
		flt[22] <= 1'b0;
		check_all();
		ctrl(CTRL_NCPON_BIT);
		check_all();
		wrn <= 4'h0;
		wm = 4'h0;
		cyc(6);
		check_all();
		results();
	end

endmodule : testbench
